/* rtl/iphp_host_port.sv */
// parallel host port: strobe sync, register file, write buffer, interrupt and line drivers
// Contract
// - write loads addressed register on rising strobe
// - read drives selected register while enabled
// - chip select high floats data bus
// - two address inputs select the register
// - eight-bit bidirectional data bus, bit0 LSB
// - interrupt is active-low open-drain pull-down
// - low reset clears registers and engine
// - scl and sda only driven low
// - bytewise transfers; engine does the sequencing
// - master and slave roles, multi-master tolerated
// - 00 status/timeout, 01 data, 10 address, 11 control
// - interrupt while si and enable both set
`timescale 1ns/10ps
module iphp_host_port #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         chip_en_n,
  input  wire logic         rd_n,
  input  wire logic         wr_n,
  input  wire logic         reg_select_low,
  input  wire logic         reg_select_high,
  input  wire logic [W-1:0] host_data_in,
  output logic      [W-1:0] host_data_out,
  output logic              host_data_oe,
  input  wire logic         reset_pin_n,
  output logic              irq_n_oe,
  output logic              irq_n_out,
  input  wire logic         scl_in,
  output logic              scl_oe,
  output logic              scl_out,
  input  wire logic         sda_in,
  output logic              sda_oe,
  output logic              sda_out,
  // engine side
  output logic              eng_wr_valid,
  input  wire logic         eng_wr_ready,
  output logic      [1:0]   eng_wr_sel,
  output logic      [W-1:0] eng_wr_data,
  output logic              eng_rd_pulse,
  output logic      [1:0]   eng_rd_sel,
  input  wire logic [W-1:0] eng_status,
  input  wire logic [W-1:0] eng_rx_data,
  input  wire logic         eng_rx_load,
  input  wire logic         eng_si_set,
  input  wire logic         eng_sto_clr,
  input  wire logic         eng_scl_low,
  input  wire logic         eng_sda_low,
  output logic              eng_reset,
  output logic              eng_enable,
  output logic      [W-1:0] eng_timeout,
  output logic      [W-1:0] eng_ownaddr,
  output logic      [W-1:0] eng_control,
  output logic              scl_sync,
  output logic              sda_sync
);

  // ==========================================================
  // pin synchronisers
  logic         ce_s;
  logic         rd_s;
  logic         wr_s;
  logic         rs_s;
  logic         scl_s;
  logic         sda_s;
  logic [1:0]   sel_s;
  logic [W-1:0] din_s;
  logic         wr_act_q;
  logic         rd_act_q;

  // idle levels as reset values, so no false strobe edge follows reset
  iphp_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) ce_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       (chip_en_n),
    .sync_q  (ce_s)
  );
  iphp_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) rd_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       (rd_n),
    .sync_q  (rd_s)
  );
  iphp_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) wr_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       (wr_n),
    .sync_q  (wr_s)
  );
  // reset pin reads as asserted until the pin is seen high twice
  iphp_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) rs_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       (reset_pin_n),
    .sync_q  (rs_s)
  );
  iphp_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) scl_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       (scl_in),
    .sync_q  (scl_s)
  );
  iphp_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) sda_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       (sda_in),
    .sync_q  (sda_s)
  );
  iphp_sync2 #(
    .WIDTH   (2),
    .RST_VAL (2'h0)
  ) sel_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       ({reg_select_high, reg_select_low}),
    .sync_q  (sel_s)
  );
  // data takes the same two flops as the strobes, so both arrive aligned
  iphp_sync2 #(
    .WIDTH   (W),
    .RST_VAL ('0)
  ) din_sync_u (
    .clk     (clk),
    .rst     (rst),
    .d       (host_data_in),
    .sync_q  (din_s)
  );

  // ==========================================================
  // strobe decode
  wire       ce_act   = ~ce_s;
  wire       wr_low   = ce_act & ~wr_s;
  wire       rd_low   = ce_act & ~rd_s;
  wire [1:0] sel      = sel_s;
  // capture happens when the write strobe rises, ending an enabled write
  wire       wr_rise  = wr_act_q & ~wr_low;
  wire       rd_fall  = rd_low & ~rd_act_q;
  wire       core_rst = rst | ~rs_s;

  logic [1:0]   wsel_q;
  logic [W-1:0] wdat_q;

  // address and data held from the last enabled cycle of the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wsel_q   <= 2'h0;
      wdat_q   <= '0;
    end else begin
      wr_act_q <= wr_low;
      rd_act_q <= rd_low;
      if (wr_low) begin
        wsel_q <= sel;
        wdat_q <= din_s;
      end
    end
  end

  // ==========================================================
  // two-entry write buffer toward the engine
  logic [W+1:0] buf_q [iphp_pkg::BUF_DEPTH];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  wire          buf_full  = (cnt_q == 2'(iphp_pkg::BUF_DEPTH));
  wire          buf_empty = (cnt_q == 2'h0);
  wire          push      = wr_rise & ~buf_full;
  wire          pop       = ~buf_empty & eng_wr_ready;

  // a write landing on a full buffer is dropped; host paces by byte
  always_ff @(posedge clk) begin
    if (core_rst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= {wsel_q, wdat_q};
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  wire [W+1:0] head = buf_q[rp_q];

  // ==========================================================
  // register file; engine writes see buffered host writes
  logic [W-1:0] tmo_q;
  logic [W-1:0] dat_q;
  logic [W-1:0] adr_q;
  logic [W-1:0] con_q;
  wire          hw   = pop;
  wire [1:0]    hsel = head[W+1:W];
  wire [W-1:0]  hdat = head[W-1:0];

  always_ff @(posedge clk) begin
    if (core_rst) begin
      tmo_q <= iphp_pkg::RST_TIMEOUT;
      dat_q <= iphp_pkg::RST_DATA;
      adr_q <= iphp_pkg::RST_OWNADDR;
      con_q <= iphp_pkg::RST_CONTROL;
    end else begin
      if (hw && hsel == iphp_pkg::SEL_STATUS) tmo_q <= hdat;
      if (eng_rx_load) dat_q <= eng_rx_data;
      else if (hw && hsel == iphp_pkg::SEL_DATA) dat_q <= hdat;
      if (hw && hsel == iphp_pkg::SEL_OWNADDR) adr_q <= hdat;
      if (hw && hsel == iphp_pkg::SEL_CONTROL) con_q <= hdat;
      // hardware set of si wins over a host clear in the same cycle
      if (eng_si_set) con_q[iphp_pkg::CON_SI] <= 1'b1;
      if (eng_sto_clr) con_q[iphp_pkg::CON_STO] <= 1'b0;
    end
  end

  wire [W-1:0] rd_mux =
      (sel == iphp_pkg::SEL_STATUS)  ? eng_status :
      (sel == iphp_pkg::SEL_DATA)    ? dat_q :
      (sel == iphp_pkg::SEL_OWNADDR) ? adr_q : con_q;

  wire irq_on = con_q[iphp_pkg::CON_SI] & con_q[iphp_pkg::CON_ENABLE];
  wire en     = con_q[iphp_pkg::CON_ENABLE];

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      host_data_out <= '0;
      host_data_oe  <= 1'b0;
      irq_n_oe      <= 1'b0;
      irq_n_out     <= 1'b0;
      scl_oe        <= 1'b0;
      scl_out       <= 1'b0;
      sda_oe        <= 1'b0;
      sda_out       <= 1'b0;
      eng_wr_valid  <= 1'b0;
      eng_wr_sel    <= 2'h0;
      eng_wr_data   <= '0;
      eng_rd_pulse  <= 1'b0;
      eng_rd_sel    <= 2'h0;
      eng_reset     <= 1'b1;
      eng_enable    <= 1'b0;
      eng_timeout   <= iphp_pkg::RST_TIMEOUT;
      eng_ownaddr   <= iphp_pkg::RST_OWNADDR;
      eng_control   <= iphp_pkg::RST_CONTROL;
      scl_sync      <= 1'b1;
      sda_sync      <= 1'b1;
    end else begin
      host_data_out <= rd_mux;
      host_data_oe  <= rd_low;
      irq_n_oe      <= irq_on & ~core_rst;
      irq_n_out     <= 1'b0;
      // lines only pulled low; released lines are sampled by the engine
      scl_oe        <= en & eng_scl_low & ~core_rst;
      scl_out       <= 1'b0;
      sda_oe        <= en & eng_sda_low & ~core_rst;
      sda_out       <= 1'b0;
      eng_wr_valid  <= pop;
      eng_wr_sel    <= hsel;
      eng_wr_data   <= hdat;
      eng_rd_pulse  <= rd_fall;
      eng_rd_sel    <= sel;
      eng_reset     <= core_rst;
      eng_enable    <= en;
      eng_timeout   <= tmo_q;
      eng_ownaddr   <= adr_q;
      eng_control   <= con_q;
      // inputs ignored while disabled
      scl_sync      <= scl_s | ~en;
      sda_sync      <= sda_s | ~en;
    end
  end

endmodule // iphp_host_port

// ==========================================================
// two-flop synchroniser; only the second flop is read outside
module iphp_sync2 #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

endmodule // iphp_sync2

/* rtl/iphp_pkg.sv */
// package of constants for the parallel host port
package iphp_pkg;
  localparam logic [1:0] SEL_STATUS  = 2'h0;
  localparam logic [1:0] SEL_DATA    = 2'h1;
  localparam logic [1:0] SEL_OWNADDR = 2'h2;
  localparam logic [1:0] SEL_CONTROL = 2'h3;
  localparam logic [7:0] RST_STATUS  = 8'hF8;
  localparam logic [7:0] RST_TIMEOUT = 8'hFF;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [7:0] RST_OWNADDR = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam int         CON_AA      = 7;
  localparam int         CON_ENABLE  = 6;
  localparam int         CON_STA     = 5;
  localparam int         CON_STO     = 4;
  localparam int         CON_SI      = 3;
  localparam int         BUF_DEPTH   = 2;
endpackage

/* dv/iphp_host_port_sva.sv */
// checker of the parallel host port outputs
`timescale 1ns/10ps
module iphp_host_port_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       chip_en_n,
  input wire logic       rd_n,
  input wire logic       reset_pin_n,
  input wire logic       host_data_oe,
  input wire logic       irq_n_oe,
  input wire logic       irq_n_out,
  input wire logic       scl_oe,
  input wire logic       scl_out,
  input wire logic       sda_oe,
  input wire logic       sda_out,
  input wire logic       eng_rd_pulse,
  input wire logic       eng_reset,
  input wire logic       eng_enable,
  input wire logic [7:0] eng_control,
  input wire logic [7:0] eng_timeout
);
  // ========
  // checks
  wire si_en = eng_control[iphp_pkg::CON_SI] & eng_control[iphp_pkg::CON_ENABLE];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  irq_level_a: assert property (!irq_n_out) else $error("irq level not low");
  line_level_a: assert property (!scl_out && !sda_out) else $error("line level high");
  irq_on_a: assert property ((si_en && !eng_reset) [*3] |-> irq_n_oe)
    else $error("irq missing");
  irq_off_a: assert property (!si_en [*3] |-> !irq_n_oe) else $error("irq stray");
  bus_float_a: assert property (chip_en_n [*5] |-> !host_data_oe) else $error("bus driven");
  bus_drive_a: assert property ((!chip_en_n && !rd_n) [*5] |-> host_data_oe)
    else $error("bus not driven");
  rd_pulse_a: assert property (eng_rd_pulse |=> !eng_rd_pulse) else $error("read pulse long");
  lines_off_a: assert property (!eng_enable [*3] |-> !scl_oe && !sda_oe)
    else $error("line pulled while disabled");
  sync_clr_a: assert property (disable iff (1'b0) rst |=> eng_timeout == 8'hFF &&
    eng_control == 8'h00) else $error("reset values wrong");
  pin_clr_a: assert property (!reset_pin_n [*5] |-> eng_control == 8'h00 && !irq_n_oe)
    else $error("reset pin ignored");
  cover property (si_en && irq_n_oe);
  cover property (eng_rd_pulse);
  cover property (scl_oe && sda_oe);
endmodule // iphp_host_port_sva
bind iphp_host_port iphp_host_port_sva chk_u (.clk(clk), .rst(rst), .chip_en_n(chip_en_n),
  .rd_n(rd_n), .reset_pin_n(reset_pin_n), .host_data_oe(host_data_oe), .irq_n_oe(irq_n_oe),
  .irq_n_out(irq_n_out), .scl_oe(scl_oe), .scl_out(scl_out), .sda_oe(sda_oe),
  .sda_out(sda_out), .eng_rd_pulse(eng_rd_pulse), .eng_reset(eng_reset),
  .eng_enable(eng_enable),
  .eng_control(eng_control), .eng_timeout(eng_timeout));

/* dv/iphp_host_model.sv */
// host model: strobed register accesses on the parallel port
`timescale 1ns/10ps
module iphp_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe,
  output logic            chip_en_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [1:0]      sel,
  output logic [7:0]      host_data_in
);
  // ========
  // bus
  logic [7:0] last_q;
  logic       drv_q;
  // released bus shows the inverse of the last value, never a stale copy
  assign host_data_in = host_data_oe ? host_data_out : (drv_q ? last_q : ~last_q);
  initial begin
    {chip_en_n, rd_n, wr_n, drv_q} = 4'hE;
    sel = 2'h0;
    last_q = 8'h00;
  end
  task automatic access(input logic [1:0] s, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk);
    sel = s;
    last_q = w ? d : last_q;
    drv_q = w;
    chip_en_n = 1'b0;
    if (w) wr_n = 1'b0; else rd_n = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    q = host_data_oe ? host_data_out : 8'hXX;
    {chip_en_n, rd_n, wr_n} = 3'h7;
    // address and data held past the synchroniser after the rising strobe
    repeat (4) @(negedge clk);
    drv_q = 1'b0;
  endtask
endmodule // iphp_host_model

/* dv/tb.sv */
// self-checking testbench of the parallel host port
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb;
  logic       clk, rst, reset_pin_n, eng_wr_ready, eng_si_set, eng_scl_low, eng_sda_low, stall;
  logic       chip_en_n, rd_n, wr_n, host_data_oe, irq_n_oe, scl_oe, sda_oe;
  logic [1:0] sel;
  logic [7:0] eng_status, host_data_in, host_data_out, eng_timeout, eng_ownaddr, eng_control, q;
  logic [7:0] shadow [4];
  logic       eng_wr_valid, eng_rd_pulse, rx_load, eng_reset, eng_enable, scl_sync, sda_sync;
  logic [1:0] eng_wr_sel, eng_rd_sel, rd_seen;
  logic [7:0] eng_wr_data, rx_data;
  logic [9:0] wr_seen;
  int         mismatches, n_checks, cyc;
  iphp_host_model host_u (.clk(clk), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .chip_en_n(chip_en_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .host_data_in(host_data_in));
  iphp_host_port dut_u (.clk(clk), .rst(rst), .chip_en_n(chip_en_n), .rd_n(rd_n), .wr_n(wr_n),
    .reg_select_low(sel[0]), .reg_select_high(sel[1]), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .reset_pin_n(reset_pin_n),
    .irq_n_oe(irq_n_oe), .irq_n_out(), .scl_in(~scl_oe), .scl_oe(scl_oe), .scl_out(),
    .sda_in(~sda_oe), .sda_oe(sda_oe), .sda_out(), .eng_wr_valid(eng_wr_valid),
    .eng_wr_ready(eng_wr_ready), .eng_wr_sel(eng_wr_sel), .eng_wr_data(eng_wr_data),
    .eng_rd_pulse(eng_rd_pulse), .eng_rd_sel(eng_rd_sel), .eng_status(eng_status),
    .eng_rx_data(rx_data), .eng_rx_load(rx_load), .eng_si_set(eng_si_set), .eng_sto_clr(1'b0),
    .eng_scl_low(eng_scl_low), .eng_sda_low(eng_sda_low), .eng_reset(eng_reset),
    .eng_enable(eng_enable), .eng_timeout(eng_timeout), .eng_ownaddr(eng_ownaddr),
    .eng_control(eng_control), .scl_sync(scl_sync), .sda_sync(sda_sync));
  // ========
  // helpers
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) eng_wr_ready <= !stall && ($urandom % 4 != 0);
  always @(posedge clk) if (eng_wr_valid) wr_seen <= {eng_wr_sel, eng_wr_data};
  always @(posedge clk) if (eng_rd_pulse) rd_seen <= eng_rd_sel;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run;
    end
  end
  function automatic logic [7:0] exp_rd(input logic [1:0] s);
    return (s == 2'h0) ? eng_status : shadow[s];
  endfunction
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    host_u.access(s, 1'b1, d, q);
    shadow[s] = d;
    // engine stalls at random, so leave room for the buffer to drain
    repeat (14) @(negedge clk);
    `CHK("engine write", {s, d}, wr_seen)
  endtask
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ========
  // scenarios
  initial begin
    {rst, reset_pin_n, stall, eng_si_set, eng_scl_low, eng_sda_low} = 6'h30;
    {eng_wr_ready, eng_status, mismatches, n_checks, cyc} = '0;
    {rx_load, rx_data} = '0;
    shadow = '{8'hFF, 8'h00, 8'h00, 8'h00};
    void'($urandom(69614));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("timeout", 8'hFF, eng_timeout)
    for (int i = 0; i < 24; i++) begin
      eng_status = 8'($urandom);
      wr(2'(i), 8'($urandom) & 8'hB7);
      `CHK("timeout", shadow[0], eng_timeout)
      `CHK("ownaddr", shadow[2], eng_ownaddr)
      `CHK("control", shadow[3], eng_control)
      host_u.access(2'(i + 1), 1'b0, 8'h00, q);
      `CHK("read", exp_rd(2'(i + 1)), q)
      `CHK("read select", 2'(i + 1), rd_seen)
    end
    rx_data = 8'($urandom);
    rx_load = 1'b1;
    @(negedge clk) rx_load = 1'b0;
    shadow[1] = rx_data;
    host_u.access(2'h1, 1'b0, 8'h00, q);
    `CHK("engine data", shadow[1], q)
    stall = 1'b1;
    for (int i = 1; i <= 3; i++) host_u.access(2'h2, 1'b1, 8'(i), q);
    `CHK("ownaddr stalled", shadow[2], eng_ownaddr)
    stall = 1'b0;
    repeat (20) @(negedge clk);
    `CHK("ownaddr drained", 8'h02, eng_ownaddr)
    host_u.wr_n = 1'b0;
    repeat (6) @(negedge clk);
    host_u.wr_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("ownaddr no select", 8'h02, eng_ownaddr)
    wr(2'h3, 8'h48);
    `CHK("irq on", 1'b1, irq_n_oe)
    `CHK("enable", 1'b1, eng_enable)
    {eng_scl_low, eng_sda_low} = 2'h3;
    repeat (4) @(negedge clk);
    `CHK("lines low", 2'h3, {scl_oe, sda_oe})
    `CHK("lines sampled", 2'h0, {scl_sync, sda_sync})
    {eng_scl_low, eng_sda_low} = 2'h0;
    wr(2'h3, 8'h40);
    `CHK("irq off", 1'b0, irq_n_oe)
    eng_si_set = 1'b1;
    @(negedge clk) eng_si_set = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("irq set", 1'b1, irq_n_oe)
    reset_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("control cleared", 8'h00, eng_control)
    `CHK("irq released", 1'b0, irq_n_oe)
    `CHK("engine reset", 1'b1, eng_reset)
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("timeout default", 8'hFF, eng_timeout)
    `CHK("engine reset off", 1'b0, eng_reset)
    complete_run;
  end
endmodule // tb
